// *** bench/stm_timer_properties.sv ***
// bus and pin relations of the standard timer, bound to its top module
module stm_timer_properties (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins and flags
  input stm_pkg::stm_pins_t pins,
  input wire logic [2:0] event_flags,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [11:0] ra_q;
  // the address of the read under way decides which answer is legal
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ra_q <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before taken");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped before taken");
  a_unmapped_error: assert property (s_axi_rvalid && ra_q >= 12'h028 |-> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  a_mapped_okay: assert property (s_axi_rvalid && ra_q < 12'h028 |-> s_axi_rresp == 2'h0)
    else $error("mapped read refused");
  a_ctrl_low_zero: assert property (s_axi_rvalid && ra_q == 12'h000 |-> s_axi_rdata[2:0] == 3'h0)
    else $error("control 0 low bits not zero");
  a_upper_byte_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  a_timer_pin_idle: assert property (!pins.oe |-> !pins.primary && !pins.complementary)
    else $error("undriven pins not idle");
  a_pin_pair: assert property (pins.oe |-> pins.complementary != pins.primary)
    else $error("complementary pin not inverse");
  c_bad_read: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_period_flag: cover property ($rose(event_flags[1]));
  c_pin_release: cover property ($fell(pins.oe));
endmodule : stm_timer_properties

bind stm_timer stm_timer_properties u_props (.aclk, .aresetn, .pins, .event_flags,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// *** bench/stm_timer_tb_top.sv ***
// register-level testbench of the standard timer
`define CHECK_EQ(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module stm_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, hi_clk_en = 0, sub_clk_en = 0;
  logic external_clock_pin = 0, capture_input_pin = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 0, tick = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, br;
  logic [2:0] event_flags;
  logic [7:0] lo;
  stm_pkg::stm_pins_t pins;
  int miscompares = 0, total_checks = 0;
  stm_timer u_dut (.aclk, .aresetn, .hi_clk_en, .sub_clk_en, .external_clock_pin,
    .capture_input_pin, .pins, .event_flags, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  always #2 aclk = ~aclk;
  // slow clock enables: high clock every 4 cycles, sub clock every 16
  always @(posedge aclk) begin
    tick <= tick + 4'h1;
    hi_clk_en <= tick[1:0] == 2'h0;
    sub_clk_en <= tick == 4'h0;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  // ready is sampled 1 ns after the edge, where it stays until the next edge
  task axi_write(input logic [11:0] a, input logic [31:0] v);
    logic aw_ok, w_ok, aw_hs, w_hs, b_hs;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      #1;
      aw_hs = s_axi_awvalid && s_axi_awready === 1'b1;
      w_hs = s_axi_wvalid && s_axi_wready === 1'b1;
      @(posedge aclk);
      if (aw_hs) begin aw_ok = 1; s_axi_awvalid <= 1'b0; end
      if (w_hs) begin w_ok = 1; s_axi_wvalid <= 1'b0; end
    end
    // bready trails bvalid by one cycle so a held answer is seen
    do begin
      #1;
      b_hs = s_axi_bvalid === 1'b1;
      br = s_axi_bresp;
      @(posedge aclk);
    end while (!b_hs);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rr);
    logic hs, got;
    hs = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!hs) begin #1; hs = s_axi_arready === 1'b1; @(posedge aclk); end
    s_axi_arvalid <= 1'b0;
    do begin #1; got = s_axi_rvalid === 1'b1; @(posedge aclk); end while (!got);
    s_axi_rready <= 1'b1;
    #1;
    v = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : axi_read
  // mode bits change only while the module is off
  task cfg(input logic [7:0] c1, input logic [7:0] c0);
    axi_write(12'h000, 32'h0);
    axi_write(12'h004, {24'h0, c1});
    axi_write(12'h01C, 32'h7);
    axi_write(12'h000, {24'h0, c0});
    #1;
  endtask : cfg
  task pulse(input int n);
    @(posedge aclk);
    repeat (n) begin
      external_clock_pin <= 1'b1;
      capture_input_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      external_clock_pin <= 1'b0;
      capture_input_pin <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask : pulse
  initial begin
    repeat (60000) @(posedge aclk);
    miscompares++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 10; i++) begin
      axi_read(12'(i * 4), d, r);
      `CHECK_EQ("reset_value", 32'h0, d)
    end
    axi_read(12'h030, d, r);
    `CHECK_EQ("unmapped_resp", 2'h2, r)
    axi_write(12'h030, 32'h0);
    `CHECK_EQ("unmapped_bresp", 2'h2, br)
    axi_write(12'h000, 32'hFF);
    axi_read(12'h000, d, r);
    `CHECK_EQ("ctrl0", 32'hF8, d)
    axi_write(12'h008, 32'hFF);
    `CHECK_EQ("count_bresp", 2'h0, br)
    axi_read(12'h008, d, r);
    `CHECK_EQ("count_write", 32'h0, d)
    axi_write(12'h010, 32'h5A);
    axi_write(12'h014, 32'hA5);
    axi_read(12'h010, d, r);
    `CHECK_EQ("duty_lo", 32'h5A, d)
    axi_read(12'h014, d, r);
    `CHECK_EQ("duty_hi", 32'hA5, d)
    for (int cs = 0; cs < 8; cs++) begin
      cfg(8'hC0, {1'b0, 3'(cs), 4'h8});
      if (cs >= 6) begin
        pulse(5);
        repeat (8) @(posedge aclk);
        axi_read(12'h008, d, r);
        `CHECK_EQ("edge_count", 32'h5, d)
      end else begin
        repeat (600) @(posedge aclk);
        axi_read(12'h008, d, r);
        `CHECK_EQ("count_runs", 1'b1, d[7:0] != 8'h0)
      end
    end
    cfg(8'hC0, 8'h18);
    repeat (50) @(posedge aclk);
    axi_write(12'h000, 32'h98);
    axi_read(12'h008, d, r);
    lo = d[7:0];
    repeat (20) @(posedge aclk);
    axi_read(12'h008, d, r);
    `CHECK_EQ("paused", lo, d[7:0])
    axi_write(12'h000, 32'h18);
    repeat (20) @(posedge aclk);
    axi_read(12'h008, d, r);
    `CHECK_EQ("resumed", 1'b1, d[7:0] > lo)
    axi_write(12'h000, 32'h10);
    axi_read(12'h008, d, r);
    lo = d[7:0];
    repeat (20) @(posedge aclk);
    axi_read(12'h008, d, r);
    `CHECK_EQ("off_holds", lo, d[7:0])
    axi_write(12'h000, 32'h18);
    axi_read(12'h008, d, r);
    `CHECK_EQ("restart", 1'b1, d[7:0] < 8'h10)
    axi_write(12'h018, 32'h1);
    axi_write(12'h010, 32'h80);
    axi_write(12'h014, 32'h0);
    cfg(8'hC0, 8'h18);
    repeat (200) @(posedge aclk);
    `CHECK_EQ("duty_flag", 2'h1, event_flags[1:0])
    repeat (100) @(posedge aclk);
    `CHECK_EQ("period_flag", 2'h3, event_flags[1:0])
    axi_read(12'h00C, d, r);
    `CHECK_EQ("period_clear", 32'h0, d)
    cfg(8'hC1, 8'h18);
    repeat (300) @(posedge aclk);
    `CHECK_EQ("duty_clear_flags", 2'h1, event_flags[1:0])
    axi_read(12'h008, d, r);
    `CHECK_EQ("duty_clear", 1'b1, d[7:0] < 8'h80)
    for (int pf = 0; pf < 4; pf++) begin
      cfg({2'h0, 2'(pf), 4'h1}, 8'h18);
      `CHECK_EQ("initial_pin", 1'b0, pins.primary)
      repeat (200) @(posedge aclk);
      `CHECK_EQ("match_pin", pf[1], pins.primary)
    end
    cfg(8'h3D, 8'h18);
    `CHECK_EQ("inverted_pin", 3'h3, pins)
    cfg(8'h88, 8'h18);
    `CHECK_EQ("pwm_inactive", 3'h3, pins)
    cfg(8'h98, 8'h18);
    `CHECK_EQ("pwm_active", 3'h5, pins)
    cfg(8'hA8, 8'h18);
    repeat (50) @(posedge aclk);
    #1;
    `CHECK_EQ("pwm_high", 3'h5, pins)
    repeat (100) @(posedge aclk);
    #1;
    `CHECK_EQ("pwm_low", 3'h3, pins)
    cfg(8'hAA, 8'h18);
    repeat (200) @(posedge aclk);
    #1;
    `CHECK_EQ("swap_duty", 3'h5, pins)
    axi_read(12'h008, d, r);
    `CHECK_EQ("swap_clear", 1'b1, d[7:0] <= 8'h80)
    cfg(8'hB8, 8'h18);
    repeat (50) @(posedge aclk);
    #1;
    `CHECK_EQ("pulse_active", 3'h5, pins)
    repeat (300) @(posedge aclk);
    #1;
    `CHECK_EQ("pulse_done", 3'h3, pins)
    cfg(8'hFC, 8'h18);
    `CHECK_EQ("timer_pins", 3'h0, pins)
    for (int pf = 0; pf < 4; pf++) begin
      cfg({2'h1, 2'(pf), 4'h0}, 8'h18);
      pulse(1);
      #1;
      `CHECK_EQ("capture_flag", pf != 3, event_flags[2])
    end
    report_and_stop;
  end
endmodule : stm_timer_tb_top

// *** design/stm_pkg.sv ***
// types of the standard timer
package stm_pkg;
  typedef enum logic [1:0] {
    STM_MODE_CMP,
    STM_MODE_CAPT,
    STM_MODE_PWM,
    STM_MODE_TMR
  } stm_mode_t;
  typedef enum logic [2:0] {
    STM_CK_SYS4,
    STM_CK_SYS,
    STM_CK_HI16,
    STM_CK_HI64,
    STM_CK_SUB_A,
    STM_CK_SUB_B,
    STM_CK_EXT_RISE,
    STM_CK_EXT_FALL
  } stm_cksel_t;
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [15:0] duty;
    logic [7:0] period;
    logic [15:0] count;
    logic [15:0] capt;
    logic [2:0] flags;
    logic on_d;
    logic [1:0] sys_div;
    logic [5:0] hi_div;
    logic [5:0] sub_div;
    logic [1:0] ext_sync;
    logic ext_d;
    logic capt_d;
    logic pin;
    logic pulse_done;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
  } stm_state_t;
  typedef struct packed {
    logic primary;
    logic complementary;
    logic oe;
  } stm_pins_t;
endpackage : stm_pkg

// *** design/stm_regs.svh ***
// register offsets, field positions and reset values of the standard timer
`ifndef STM_REGS_SVH
`define STM_REGS_SVH
`define STM_OFF_CTRL0 12'h000
`define STM_OFF_CTRL1 12'h004
`define STM_OFF_CNT_LO 12'h008
`define STM_OFF_CNT_HI 12'h00C
`define STM_OFF_DUTY_LO 12'h010
`define STM_OFF_DUTY_HI 12'h014
`define STM_OFF_PERIOD 12'h018
`define STM_OFF_FLAGS 12'h01C
`define STM_OFF_CAPT_LO 12'h020
`define STM_OFF_CAPT_HI 12'h024
`define STM_C0_PAUSE 7
`define STM_C0_CKSEL_HI 6
`define STM_C0_CKSEL_LO 4
`define STM_C0_ON 3
`define STM_C0_MASK 8'hF8
`define STM_C1_MODE_HI 7
`define STM_C1_MODE_LO 6
`define STM_C1_PINF_HI 5
`define STM_C1_PINF_LO 4
`define STM_C1_OC 3
`define STM_C1_POL 2
`define STM_C1_DPX 1
`define STM_C1_CCLR 0
`define STM_FLAG_DUTY 0
`define STM_FLAG_PERIOD 1
`define STM_FLAG_CAPT 2
`define STM_RST_BYTE 8'h00
`define STM_DIV_HI16 6'd15
`define STM_DIV_HI64 6'd63
`define STM_DIV_SUB 6'd63
`endif

// *** design/stm_timer.sv ***
// standard timer: 16-bit up counter, two comparators, pin modes, AXI4-Lite registers
`include "stm_regs.svh"
module stm_timer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // internal clock enables
  input wire logic hi_clk_en,
  input wire logic sub_clk_en,
  // external pins
  input wire logic external_clock_pin,
  input wire logic capture_input_pin,
  output stm_pkg::stm_pins_t pins,
  // event flags, level
  output logic [2:0] event_flags,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  stm_pkg::stm_state_t st_reg;
  stm_pkg::stm_state_t st_next;
  stm_pkg::stm_mode_t mode;
  stm_pkg::stm_cksel_t cksel;
  logic on_bit;
  logic [1:0] pinf;
  logic oc;
  logic tick;
  logic ext_rise;
  logic ext_fall;
  logic ext_s;
  logic duty_hit;
  logic period_hit;
  logic ovf;
  logic clr;
  logic pwm_duty;
  logic pwm_per;
  logic wave;
  logic level;
  logic capt_edge;
  logic wr_go;
  logic [7:0] rbyte;

  assign mode = stm_pkg::stm_mode_t'(st_reg.ctrl1[`STM_C1_MODE_HI:`STM_C1_MODE_LO]);
  assign cksel = stm_pkg::stm_cksel_t'(st_reg.ctrl0[`STM_C0_CKSEL_HI:`STM_C0_CKSEL_LO]);
  assign on_bit = st_reg.ctrl0[`STM_C0_ON];
  assign pinf = st_reg.ctrl1[`STM_C1_PINF_HI:`STM_C1_PINF_LO];
  assign oc = st_reg.ctrl1[`STM_C1_OC];
  assign ext_s = st_reg.ext_sync[1];
  // only the second synchroniser stage feeds edge detection
  assign ext_rise = ext_s & ~st_reg.ext_d;
  assign ext_fall = ~ext_s & st_reg.ext_d;

  always_comb begin
    tick = 1'b0;
    case (cksel)
      stm_pkg::STM_CK_SYS4: tick = (st_reg.sys_div == 2'd3);
      stm_pkg::STM_CK_SYS: tick = 1'b1;
      stm_pkg::STM_CK_HI16: tick = hi_clk_en && (st_reg.hi_div[3:0] == 4'(`STM_DIV_HI16));
      stm_pkg::STM_CK_HI64: tick = hi_clk_en && (st_reg.hi_div == `STM_DIV_HI64);
      stm_pkg::STM_CK_SUB_A: tick = sub_clk_en;
      stm_pkg::STM_CK_SUB_B: tick = sub_clk_en;
      stm_pkg::STM_CK_EXT_RISE: tick = ext_rise;
      default: tick = ext_fall;
    endcase
    // counting needs on and not paused
    tick = tick && on_bit && st_reg.on_d && !st_reg.ctrl0[`STM_C0_PAUSE];
  end

  // comparators look at the count held when the tick arrives, before the tick moves it on
  assign duty_hit = tick && (st_reg.count == st_reg.duty);
  // match on the last count before the upper byte reaches the period, so N gives N*256 ticks
  assign period_hit = tick && (st_reg.period != 8'h00)
                      && (st_reg.count[15:8] == st_reg.period - 8'h01)
                      && (st_reg.count[7:0] == 8'hFF);
  assign ovf = tick && (st_reg.count == 16'hFFFF);

  always_comb begin
    pwm_duty = 1'b0;
    pwm_per = 1'b0;
    clr = 1'b0;
    if (mode == stm_pkg::STM_MODE_PWM) begin
      // swap exchanges which comparator ends the period
      pwm_per = st_reg.ctrl1[`STM_C1_DPX] ? duty_hit : (period_hit | ovf);
      clr = pwm_per;
    end else if (st_reg.ctrl1[`STM_C1_CCLR]) begin
      clr = duty_hit;
    end else begin
      clr = period_hit | ovf;
    end
    // wave is active while count stays below the duty boundary
    if (st_reg.ctrl1[`STM_C1_DPX]) begin
      pwm_duty = (st_reg.period == 8'h00) || (st_reg.count[15:8] < st_reg.period);
    end else begin
      pwm_duty = st_reg.count < st_reg.duty;
    end
  end

  assign capt_edge = (mode == stm_pkg::STM_MODE_CAPT) && on_bit && (
      (pinf == 2'b00 && capture_input_pin && !st_reg.capt_d) ||
      (pinf == 2'b01 && !capture_input_pin && st_reg.capt_d) ||
      (pinf == 2'b10 && (capture_input_pin != st_reg.capt_d)));

  assign wr_go = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;

  always_comb begin
    st_next = st_reg;
    st_next.on_d = on_bit;
    st_next.sys_div = st_reg.sys_div + 2'd1;
    if (hi_clk_en) begin
      st_next.hi_div = st_reg.hi_div + 6'd1;
    end
    if (sub_clk_en) begin
      st_next.sub_div = st_reg.sub_div + 6'd1;
    end
    st_next.ext_sync = {st_reg.ext_sync[0], external_clock_pin};
    st_next.ext_d = ext_s;
    st_next.capt_d = capture_input_pin;
    // counter
    if (on_bit && !st_reg.on_d) begin
      st_next.count = 16'h0000;
      st_next.pulse_done = 1'b0;
      st_next.pin = oc;
    end else if (tick) begin
      if (clr) begin
        st_next.count = 16'h0000;
      end else begin
        st_next.count = st_reg.count + 16'h0001;
      end
    end
    if (mode == stm_pkg::STM_MODE_CMP && duty_hit && st_reg.on_d) begin
      case (pinf)
        2'b01: st_next.pin = 1'b0;
        2'b10: st_next.pin = 1'b1;
        2'b11: st_next.pin = ~st_reg.pin;
        default: st_next.pin = st_reg.pin;
      endcase
    end
    if (mode == stm_pkg::STM_MODE_PWM && pinf == 2'b11 && pwm_per) begin
      st_next.pulse_done = 1'b1;
    end
    if (capt_edge) begin
      st_next.capt = st_reg.count;
    end
    // axi write channel capture
    if (s_axi_awvalid && !st_reg.aw_got) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_got) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (wr_go) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = 2'b00;
      if (st_reg.wstrb[0]) begin
        if (st_reg.awaddr == `STM_OFF_CTRL0) begin
          st_next.ctrl0 = st_reg.wdata[7:0] & `STM_C0_MASK;
        end else if (st_reg.awaddr == `STM_OFF_CTRL1) begin
          st_next.ctrl1 = st_reg.wdata[7:0];
        end else if (st_reg.awaddr == `STM_OFF_DUTY_LO) begin
          st_next.duty[7:0] = st_reg.wdata[7:0];
        end else if (st_reg.awaddr == `STM_OFF_DUTY_HI) begin
          st_next.duty[15:8] = st_reg.wdata[7:0];
        end else if (st_reg.awaddr == `STM_OFF_PERIOD) begin
          st_next.period = st_reg.wdata[7:0];
        end else if (st_reg.awaddr == `STM_OFF_FLAGS) begin
          st_next.flags = st_reg.flags & ~st_reg.wdata[2:0];
        end else if (st_reg.awaddr == `STM_OFF_CNT_LO || st_reg.awaddr == `STM_OFF_CNT_HI
                     || st_reg.awaddr == `STM_OFF_CAPT_LO
                     || st_reg.awaddr == `STM_OFF_CAPT_HI) begin
          st_next.bresp = 2'b00;
        end else begin
          st_next.bresp = 2'b10;
        end
      end
    end
    // flags set after the clear so a same-cycle event wins
    if (duty_hit && (mode == stm_pkg::STM_MODE_PWM || st_reg.duty != 16'h0000
                     || !st_reg.ctrl1[`STM_C1_CCLR])) begin
      st_next.flags[`STM_FLAG_DUTY] = 1'b1;
    end
    if ((period_hit || (ovf && st_reg.period == 8'h00))
        && (mode == stm_pkg::STM_MODE_PWM || !st_reg.ctrl1[`STM_C1_CCLR])) begin
      st_next.flags[`STM_FLAG_PERIOD] = 1'b1;
    end
    if (capt_edge) begin
      st_next.flags[`STM_FLAG_CAPT] = 1'b1;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // axi read
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = 2'b00;
      rbyte = 8'h00;
      if (s_axi_araddr == `STM_OFF_CTRL0) begin
        rbyte = st_reg.ctrl0 & `STM_C0_MASK;
      end else if (s_axi_araddr == `STM_OFF_CTRL1) begin
        rbyte = st_reg.ctrl1;
      end else if (s_axi_araddr == `STM_OFF_CNT_LO) begin
        rbyte = st_reg.count[7:0];
      end else if (s_axi_araddr == `STM_OFF_CNT_HI) begin
        rbyte = st_reg.count[15:8];
      end else if (s_axi_araddr == `STM_OFF_DUTY_LO) begin
        rbyte = st_reg.duty[7:0];
      end else if (s_axi_araddr == `STM_OFF_DUTY_HI) begin
        rbyte = st_reg.duty[15:8];
      end else if (s_axi_araddr == `STM_OFF_PERIOD) begin
        rbyte = st_reg.period;
      end else if (s_axi_araddr == `STM_OFF_FLAGS) begin
        rbyte = {5'h00, st_reg.flags};
      end else if (s_axi_araddr == `STM_OFF_CAPT_LO) begin
        rbyte = st_reg.capt[7:0];
      end else if (s_axi_araddr == `STM_OFF_CAPT_HI) begin
        rbyte = st_reg.capt[15:8];
      end else begin
        st_next.rresp = 2'b10;
      end
      st_next.rdata = {24'h000000, rbyte};
    end else begin
      rbyte = 8'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // output pin
  always_comb begin
    wave = 1'b0;
    case (pinf)
      2'b00: wave = 1'b0;
      2'b01: wave = 1'b1;
      2'b10: wave = pwm_duty && on_bit;
      default: wave = pwm_duty && on_bit && !st_reg.pulse_done;
    endcase
    if (mode == stm_pkg::STM_MODE_PWM) begin
      level = oc ? wave : ~wave;
    end else begin
      level = st_reg.pin;
    end
    level = level ^ st_reg.ctrl1[`STM_C1_POL];
  end

  // undriven pins rest low, in capture mode as well as in timer mode
  assign pins.primary = pins.oe ? level : 1'b0;
  assign pins.complementary = pins.oe ? ~level : 1'b0;
  assign pins.oe = (mode == stm_pkg::STM_MODE_CMP) || (mode == stm_pkg::STM_MODE_PWM);
  assign event_flags = st_reg.flags;

  assign s_axi_awready = !st_reg.aw_got;
  assign s_axi_wready = !st_reg.w_got;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
endmodule : stm_timer
